// ---- hdl/bbsc_pkg.sv ----
// Shared constants for the battery-backed seconds clock.
// Assumes a single 200 MHz ref_clk shared by both ends.
package bbsc_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_TIMEKEEPER_CONTROL_HIGH = 8'h00;
  localparam logic [7:0] OFF_TIMEKEEPER_CONTROL_LOW  = 8'h04;
  localparam logic [7:0] OFF_RELOAD                  = 8'h08;
  localparam logic [7:0] OFF_DIVIDER                 = 8'h0C;
  localparam logic [7:0] OFF_COUNT                   = 8'h10;
  localparam logic [7:0] OFF_ALARM                   = 8'h14;
  localparam logic [7:0] OFF_BACKUP_DOMAIN_CONTROL   = 8'h18;
  localparam logic [7:0] OFF_BACKUP_DATA0            = 8'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CH_SECOND_IE   = 0;
  localparam int CH_OVERFLOW_IE = 1;
  localparam int CH_ALARM_IE    = 2;
  localparam int CL_SECOND_F    = 0;
  localparam int CL_ALARM_F     = 1;
  localparam int CL_OVERFLOW_F  = 2;
  localparam int CL_SYNC_F      = 3;
  localparam int CL_WRITE_DONE  = 5;
  localparam int BD_XTAL_EN     = 0;
  localparam int BD_XTAL_RDY    = 1;
  localparam int BD_XTAL_BYP    = 2;
  localparam int BD_SRC_LSB     = 8;
  localparam int BD_CAL_OUT     = 14;
  localparam int BD_CLK_EN      = 15;

  // ************************************************************
  // Reset values and dividers
  // ************************************************************
  localparam logic [19:0] RST_RELOAD = 20'h00000;
  localparam logic [31:0] RST_COUNT  = 32'h00000000;
  localparam logic [31:0] RST_ALARM  = 32'hFFFFFFFF;
  localparam int HSE_DIV          = 128;
  localparam int HSE_DIV_W        = $clog2(HSE_DIV);
  localparam int CAL_DIV          = 64;
  localparam int CAL_HALF_W       = $clog2(CAL_DIV / 2);
  localparam int XTAL_READY_EDGES = 16;

  // ************************************************************
  // Modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_XTAL = 2'h1,
    SRC_RC   = 2'h2,
    SRC_HSE  = 2'h3
  } bbsc_src_e;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_ACCESS, H_POLL_SETUP, H_POLL_ACCESS
  } bbsc_host_e;

endpackage

// ---- hdl/bbsc_apb_if.sv ----
// Peripheral bus between the processor end and the clock block.
// Assumes both ends run on the same ref_clk.
interface bbsc_apb_if;
  import bbsc_pkg::*;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              backupWriteUnlock;

  modport host (output psel, penable, pwrite, paddr, pwdata,
                output backupWriteUnlock,
                input  prdata, pready, pslverr);
  modport dev  (input  psel, penable, pwrite, paddr, pwdata,
                input  backupWriteUnlock,
                output prdata, pready, pslverr);
endinterface

// ---- hdl/bbsc_slow_src.sv ----
// Slow clock source selection and crystal start-up check.
// Assumes source inputs are synchronous levels slower than ref_clk/2.
module bbsc_slow_src
  import bbsc_pkg::*;
#(
  parameter int READY_EDGES = XTAL_READY_EDGES
) (
  input  logic      ref_clk,
  input  logic      rst_b,
  input  logic      lowSpeedCrystalClock,
  input  logic      internalSlowOscillator,
  input  logic      highSpeedCrystalClock,
  input  logic      crystalOscillatorEnable,
  input  logic      timekeeperClockEnable,
  input  bbsc_src_e slowClockSourceSelect,
  output logic      slowEdge,
  output logic      crystalReadyFlag
);
  localparam int RDY_W = $clog2(READY_EDGES + 1);

  typedef struct packed {
    logic                 xtalQ;
    logic                 rcQ;
    logic                 hseQ;
    logic [HSE_DIV_W-1:0] hseCnt;
    logic [RDY_W-1:0]     rdyCnt;
    logic                 ready;
    logic                 edgeQ;
  } bbsc_src_s;

  bbsc_src_s s;
  bbsc_src_s n;
  logic      xtalRise;
  logic      hseTick;
  logic      pick;

  always_comb begin
    n        = s;
    // Oscillator output is dead while not enabled
    n.xtalQ  = lowSpeedCrystalClock & crystalOscillatorEnable;
    n.rcQ    = internalSlowOscillator;
    n.hseQ   = highSpeedCrystalClock;
    xtalRise = n.xtalQ & ~s.xtalQ;
    hseTick  = 1'h0;
    if (n.hseQ && !s.hseQ) begin
      n.hseCnt = s.hseCnt + 1'h1;
      hseTick  = (s.hseCnt == HSE_DIV_W'(HSE_DIV - 1));
    end
    // Ready after a run of clean edges; a stalled crystal never gets here
    if (!crystalOscillatorEnable) begin
      n.rdyCnt = '0;
      n.ready  = 1'h0;
    end else if (xtalRise && !s.ready) begin
      n.rdyCnt = s.rdyCnt + 1'h1;
      n.ready  = (s.rdyCnt == RDY_W'(READY_EDGES - 1));
    end
    case (slowClockSourceSelect)
      SRC_XTAL: pick = xtalRise;
      SRC_RC:   pick = n.rcQ & ~s.rcQ;
      SRC_HSE:  pick = hseTick;
      default:  pick = 1'h0;
    endcase
    n.edgeQ = pick & timekeeperClockEnable;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign slowEdge         = s.edgeQ;
  assign crystalReadyFlag = s.ready;
endmodule

// ---- hdl/bbsc_device.sv ----
// Battery-backed seconds clock: register file, prescaler, counter.
// Assumes rst_b is the backup-domain power-on reset only.
module bbsc_device
  import bbsc_pkg::*;
#(
  parameter int PRE_W       = 20,
  parameter int NUM_BKP     = 10,
  parameter int READY_EDGES = XTAL_READY_EDGES
) (
  input  logic ref_clk,
  input  logic rst_b,
  bbsc_apb_if.dev bus,
  input  logic lowSpeedCrystalClock,
  input  logic internalSlowOscillator,
  input  logic highSpeedCrystalClock,
  output logic crystalOscillatorOn,
  output logic secondIrq,
  output logic overflowIrq,
  output logic alarmIrq,
  output logic externalInterruptLineWakeup,
  output logic tamperOut,
  output logic tamperOe
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                         secondInterruptEnable;
    logic                         overflowIe;
    logic                         alarmIe;
    logic                         secondF;
    logic                         overflowF;
    logic                         alarmF;
    logic                         registersSynchronizedFlag;
    logic [PRE_W-1:0]             prescalerReloadValue;
    logic [PRE_W-1:0]             divider;
    logic [31:0]                  count;
    logic [31:0]                  alarm;
    logic [PRE_W-1:0]             pendReload;
    logic [31:0]                  pendCount;
    logic [31:0]                  pendAlarm;
    logic [2:0]                   pend;
    logic                         crystalOscillatorEnable;
    logic                         crystalBypass;
    logic                         timekeeperClockEnable;
    logic                         calibrationClockOutputEnable;
    logic [1:0]                   slowClockSourceSelect;
    logic [NUM_BKP-1:0][15:0]     bkp;
    logic [CAL_HALF_W-1:0]        calCnt;
    logic                         tamperOut;
    logic                         tamperOe;
    logic                         secondIrq;
    logic                         overflowIrq;
    logic                         alarmIrq;
    logic                         wake;
    logic                         oscOn;
    logic                         pready;
    logic                         pslverr;
    logic [DATA_W-1:0]            prdata;
  } bbsc_dev_s;

  localparam int P_RELOAD = 0;
  localparam int P_COUNT  = 1;
  localparam int P_ALARM  = 2;

  bbsc_dev_s         s;
  bbsc_dev_s         n;
  logic              slowEdge;
  logic              crystalReadyFlag;
  logic              acc;
  logic              tick;
  logic              hit;
  logic              refuse;
  logic              writeCompleteFlag;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] wd;
  logic [31:0]       countInc;

  function automatic logic inBkp(input logic [ADDR_W-1:0] a);
    return a >= OFF_BACKUP_DATA0 && a[1:0] == 2'h0 &&
           a < ADDR_W'(OFF_BACKUP_DATA0 + 4 * NUM_BKP);
  endfunction

  function automatic logic [3:0] bkpIdx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFF_BACKUP_DATA0;
    return d[5:2];
  endfunction

  // ************************************************************
  // Slow clock source
  // ************************************************************
  bbsc_slow_src #(
    .READY_EDGES (READY_EDGES)
  ) u_src (
    .ref_clk                 (ref_clk),
    .rst_b                   (rst_b),
    .lowSpeedCrystalClock    (lowSpeedCrystalClock),
    .internalSlowOscillator  (internalSlowOscillator),
    .highSpeedCrystalClock   (highSpeedCrystalClock),
    .crystalOscillatorEnable (s.crystalOscillatorEnable),
    .timekeeperClockEnable   (s.timekeeperClockEnable),
    .slowClockSourceSelect   (bbsc_src_e'(s.slowClockSourceSelect)),
    .slowEdge                (slowEdge),
    .crystalReadyFlag        (crystalReadyFlag)
  );

  // ************************************************************
  // Bus access and time-keeping core
  // ************************************************************
  always_comb begin
    n                 = s;
    n.pready          = 1'h0;
    n.pslverr         = 1'h0;
    writeCompleteFlag = ~|s.pend;
    wd                = bus.pwdata;
    // One wait state: the answer is registered
    acc               = bus.psel & bus.penable & ~s.pready;
    rd                = '0;
    hit               = 1'h1;
    case (bus.paddr)
      OFF_TIMEKEEPER_CONTROL_HIGH: begin
        rd[CH_SECOND_IE]   = s.secondInterruptEnable;
        rd[CH_OVERFLOW_IE] = s.overflowIe;
        rd[CH_ALARM_IE]    = s.alarmIe;
      end
      OFF_TIMEKEEPER_CONTROL_LOW: begin
        rd[CL_SECOND_F]   = s.secondF;
        rd[CL_ALARM_F]    = s.alarmF;
        rd[CL_OVERFLOW_F] = s.overflowF;
        rd[CL_SYNC_F]     = s.registersSynchronizedFlag;
        rd[CL_WRITE_DONE] = writeCompleteFlag;
      end
      OFF_RELOAD:  rd[PRE_W-1:0] = s.prescalerReloadValue;
      OFF_DIVIDER: rd[PRE_W-1:0] = s.divider;
      OFF_COUNT:   rd            = s.count;
      OFF_ALARM:   rd            = s.alarm;
      OFF_BACKUP_DOMAIN_CONTROL: begin
        rd[BD_XTAL_EN]                = s.crystalOscillatorEnable;
        rd[BD_XTAL_RDY]               = crystalReadyFlag;
        rd[BD_XTAL_BYP]               = s.crystalBypass;
        rd[BD_SRC_LSB+1:BD_SRC_LSB]   = s.slowClockSourceSelect;
        rd[BD_CAL_OUT]                = s.calibrationClockOutputEnable;
        rd[BD_CLK_EN]                 = s.timekeeperClockEnable;
      end
      default: begin
        if (inBkp(bus.paddr)) begin
          rd[15:0] = s.bkp[bkpIdx(bus.paddr)];
        end else begin
          hit = 1'h0;
        end
      end
    endcase
    // Timed registers refuse a second write until the first lands
    refuse = bus.pwrite && (!bus.backupWriteUnlock ||
             (!writeCompleteFlag && (bus.paddr == OFF_RELOAD ||
              bus.paddr == OFF_COUNT || bus.paddr == OFF_ALARM)));
    if (acc) begin
      n.pready  = 1'h1;
      n.prdata  = bus.pwrite ? '0 : rd;
      n.pslverr = ~hit | refuse;
      if (bus.pwrite && hit && !refuse) begin
        case (bus.paddr)
          OFF_TIMEKEEPER_CONTROL_HIGH: begin
            n.secondInterruptEnable = wd[CH_SECOND_IE];
            n.overflowIe            = wd[CH_OVERFLOW_IE];
            n.alarmIe               = wd[CH_ALARM_IE];
          end
          OFF_TIMEKEEPER_CONTROL_LOW: begin
            // Flags clear on a written zero; a set below still wins
            n.secondF   = s.secondF & wd[CL_SECOND_F];
            n.alarmF    = s.alarmF & wd[CL_ALARM_F];
            n.overflowF = s.overflowF & wd[CL_OVERFLOW_F];
            n.registersSynchronizedFlag =
              s.registersSynchronizedFlag & wd[CL_SYNC_F];
          end
          OFF_RELOAD: begin
            n.pendReload     = wd[PRE_W-1:0];
            n.pend[P_RELOAD] = 1'h1;
          end
          OFF_COUNT: begin
            n.pendCount     = wd;
            n.pend[P_COUNT] = 1'h1;
          end
          OFF_ALARM: begin
            n.pendAlarm     = wd;
            n.pend[P_ALARM] = 1'h1;
          end
          OFF_DIVIDER: begin
            // Read-only: the write is answered and dropped
          end
          OFF_BACKUP_DOMAIN_CONTROL: begin
            n.crystalOscillatorEnable      = wd[BD_XTAL_EN];
            n.crystalBypass                = wd[BD_XTAL_BYP];
            n.slowClockSourceSelect = wd[BD_SRC_LSB+1:BD_SRC_LSB];
            n.calibrationClockOutputEnable = wd[BD_CAL_OUT];
            n.timekeeperClockEnable        = wd[BD_CLK_EN];
          end
          default: begin
            n.bkp[bkpIdx(bus.paddr)] = wd[15:0];
          end
        endcase
      end
    end

    tick     = 1'h0;
    countInc = s.count + 1'h1;
    if (slowEdge) begin
      n.registersSynchronizedFlag = 1'h1;
      if (s.divider == '0) begin
        tick      = 1'h1;
        n.divider = s.prescalerReloadValue;
      end else begin
        n.divider = s.divider - 1'h1;
      end
      if (s.pend[P_RELOAD]) begin
        n.prescalerReloadValue = s.pendReload;
        n.divider              = s.pendReload;
        n.pend[P_RELOAD]       = 1'h0;
      end
      if (s.pend[P_ALARM]) begin
        n.alarm         = s.pendAlarm;
        n.pend[P_ALARM] = 1'h0;
      end
      if (s.pend[P_COUNT]) begin
        n.count         = s.pendCount;
        n.pend[P_COUNT] = 1'h0;
      end else if (tick) begin
        n.count = countInc;
        n.secondF = 1'h1;
        if (s.count == 32'hFFFFFFFF) begin
          n.overflowF = 1'h1;
        end
        if (countInc == s.alarm) begin
          n.alarmF = 1'h1;
        end
      end
      // Slow clock / 64 on the tamper pin for calibration
      if (s.calibrationClockOutputEnable) begin
        n.calCnt = s.calCnt + 1'h1;
        if (s.calCnt == CAL_HALF_W'(CAL_DIV / 2 - 1)) begin
          n.tamperOut = ~s.tamperOut;
        end
      end
    end
    if (!s.calibrationClockOutputEnable) begin
      n.calCnt    = '0;
      n.tamperOut = 1'h0;
    end
    n.tamperOe     = n.calibrationClockOutputEnable;
    n.oscOn        = n.crystalOscillatorEnable & ~n.crystalBypass;
    n.secondIrq    = n.secondF & n.secondInterruptEnable;
    n.overflowIrq  = n.overflowF & n.overflowIe;
    n.alarmIrq     = n.alarmF & n.alarmIe;
    n.wake         = n.alarmF;
  end

  // Only the backup-domain reset reaches this state; system and
  // standby resets are not wired in at all
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s                      <= '0;
      s.prescalerReloadValue <= RST_RELOAD;
      s.count                <= RST_COUNT;
      s.alarm                <= RST_ALARM;
    end else begin
      s <= n;
    end
  end

  assign bus.prdata                  = s.prdata;
  assign bus.pready                  = s.pready;
  assign bus.pslverr                 = s.pslverr;
  assign crystalOscillatorOn         = s.oscOn;
  assign secondIrq                   = s.secondIrq;
  assign overflowIrq                 = s.overflowIrq;
  assign alarmIrq                    = s.alarmIrq;
  assign externalInterruptLineWakeup = s.wake;
  assign tamperOut                   = s.tamperOut;
  assign tamperOe                    = s.tamperOe;
endmodule

// ---- hdl/bbsc_host.sv ----
// Processor-side bus master for the seconds clock.
// Assumes one command at a time on the user side.
module bbsc_host
  import bbsc_pkg::*;
(
  input  logic              ref_clk,
  input  logic              rst_b,
  bbsc_apb_if.host          bus,
  input  logic              backupWriteUnlock,
  input  logic              cmdValid,
  input  logic              cmdWrite,
  input  logic [ADDR_W-1:0] cmdAddr,
  input  logic [DATA_W-1:0] cmdWdata,
  output logic              cmdReady,
  output logic              rspValid,
  output logic [DATA_W-1:0] rspRdata,
  output logic              rspErr
);

  typedef struct packed {
    bbsc_host_e        state;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic              unlock;
    logic              cmdReady;
    logic              rspValid;
    logic [DATA_W-1:0] rspRdata;
    logic              rspErr;
  } bbsc_host_s;

  bbsc_host_s s;
  bbsc_host_s n;

  function automatic logic isTimed(input logic [ADDR_W-1:0] a);
    return a == OFF_RELOAD || a == OFF_COUNT || a == OFF_ALARM;
  endfunction

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  always_comb begin
    n          = s;
    n.rspValid = 1'h0;
    n.unlock   = backupWriteUnlock;
    case (s.state)
      H_IDLE: begin
        if (cmdValid) begin
          n.paddr    = cmdAddr;
          n.pwrite   = cmdWrite;
          n.pwdata   = cmdWdata;
          n.psel     = 1'h1;
          n.cmdReady = 1'h0;
          n.state    = H_SETUP;
        end
      end
      H_SETUP: begin
        n.penable = 1'h1;
        n.state   = H_ACCESS;
      end
      H_ACCESS: begin
        if (bus.pready) begin
          n.penable  = 1'h0;
          n.rspValid = 1'h1;
          n.rspRdata = bus.prdata;
          n.rspErr   = bus.pslverr;
          // Hold off the next command until the slow side has it
          if (s.pwrite && !bus.pslverr && isTimed(s.paddr)) begin
            n.paddr  = OFF_TIMEKEEPER_CONTROL_LOW;
            n.pwrite = 1'h0;
            n.state  = H_POLL_SETUP;
          end else begin
            n.psel     = 1'h0;
            n.cmdReady = 1'h1;
            n.state    = H_IDLE;
          end
        end
      end
      H_POLL_SETUP: begin
        n.penable = 1'h1;
        n.state   = H_POLL_ACCESS;
      end
      H_POLL_ACCESS: begin
        if (bus.pready) begin
          n.penable = 1'h0;
          if (bus.prdata[CL_WRITE_DONE]) begin
            n.psel     = 1'h0;
            n.cmdReady = 1'h1;
            n.state    = H_IDLE;
          end else begin
            n.state = H_POLL_SETUP;
          end
        end
      end
      default: begin
        n.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s          <= '0;
      s.state    <= H_IDLE;
      s.cmdReady <= 1'h1;
    end else begin
      s <= n;
    end
  end

  assign bus.psel              = s.psel;
  assign bus.penable           = s.penable;
  assign bus.pwrite            = s.pwrite;
  assign bus.paddr             = s.paddr;
  assign bus.pwdata            = s.pwdata;
  assign bus.backupWriteUnlock = s.unlock;
  assign cmdReady              = s.cmdReady;
  assign rspValid              = s.rspValid;
  assign rspRdata              = s.rspRdata;
  assign rspErr                = s.rspErr;
endmodule

// ---- dv/bbsc_monitor.sv ----
// Bus checker for the seconds clock, fed from the interface wires.
// Assumes one ref_clk domain and rst_b active low.
module bbsc_monitor
  import bbsc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              backupWriteUnlock
);
  // ************************************************************
  // Phases
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic inBackup = paddr >= 8'h20 && paddr <= 8'h44;
  sequence setup_s; psel && !penable; endsequence
  sequence wait_s; psel && penable && !pready; endsequence

  // ************************************************************
  // Checks
  // ************************************************************
  setup_then_access_a: assert property (
    setup_s |=> psel && penable)
    else $error("access phase missing");
  one_wait_a: assert property (wait_s |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  request_hold_a: assert property (
    wait_s |=> $stable(paddr) && $stable(pwrite) && $stable(pwdata))
    else $error("request moved");
  locked_write_a: assert property (
    (wait_s and (pwrite && !backupWriteUnlock)) |=> pslverr)
    else $error("locked write taken");
  open_write_a: assert property (
    (wait_s and (pwrite && backupWriteUnlock && inBackup)) |=> !pslverr)
    else $error("open write refused");
  backup_upper_a: assert property (
    (wait_s and (!pwrite && inBackup)) |=> prdata[31:16] == 16'h0000)
    else $error("backup upper bits");
  reload_width_a: assert property (
    (wait_s and (!pwrite && paddr == OFF_RELOAD))
    |=> prdata[31:20] == 12'h000) else $error("reload too wide");
  hole_err_a: assert property (
    (wait_s and (paddr >= 8'h48)) |=> pslverr)
    else $error("unmapped taken");
endmodule

// ---- dv/bbsc_bench.sv ----
// Bench joining processor end and clock block over the bus.
// Assumes one slow source shared by all three source inputs.
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin \
  nMismatch++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module bbsc_bench
  import bbsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_b = 1'b0, slowClk = 1'b0, unlock = 1'b0;
  logic cmdValid = 1'b0, cmdWrite = 1'b0, cmdReady, rspValid, rspErr, errv;
  logic [7:0] cmdAddr = 8'h00;
  logic [31:0] cmdWdata = 32'h0, rspRdata, rdv;
  logic oscOn, secIrq, ovfIrq, alrIrq, wake, tamperOe, tamperPin;
  logic [2:0] div = 3'h0;
  int nMismatch = 0, nChecks = 0, cycles = 0, i;
  bbsc_apb_if bus();
  bbsc_device #(.READY_EDGES(2)) bbsc_device_inst(.ref_clk(ref_clk),
    .rst_b(rst_b), .bus(bus), .lowSpeedCrystalClock(slowClk),
    .internalSlowOscillator(slowClk), .highSpeedCrystalClock(slowClk),
    .crystalOscillatorOn(oscOn), .secondIrq(secIrq), .overflowIrq(ovfIrq),
    .alarmIrq(alrIrq), .externalInterruptLineWakeup(wake),
    .tamperOut(tamperPin), .tamperOe(tamperOe));
  bbsc_host bbsc_host_inst(.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
    .backupWriteUnlock(unlock), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspRdata(rspRdata), .rspErr(rspErr));
  bbsc_monitor bbsc_monitor_inst(.ref_clk(ref_clk), .rst_b(rst_b),
    .psel(bus.psel), .penable(bus.penable), .pwrite(bus.pwrite),
    .paddr(bus.paddr), .pwdata(bus.pwdata), .prdata(bus.prdata),
    .pready(bus.pready), .pslverr(bus.pslverr),
    .backupWriteUnlock(bus.backupWriteUnlock));

  // ************************************************************
  // Clock, slow source and hang guard
  // ************************************************************
  initial forever #2.5 ref_clk = ~ref_clk;
  // Slow source at ref_clk/8, well under the ref_clk/2 limit
  always @(posedge ref_clk) begin
    div <= div + 3'h1;
    slowClk <= div[2];
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      nMismatch++;
      close_out();
    end
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdAddr <= a;
    cmdWdata <= d;
    do @(posedge ref_clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do @(posedge ref_clk); while (rspValid !== 1'b1);
    rdv = rspRdata;
    errv = rspErr;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input string nm);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, ex, rdv)
  endtask
  task close_out;
    $display("mismatches %0d checks %0d", nMismatch, nChecks);
    if (nMismatch == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(OFF_ALARM, RST_ALARM, "alarm reset");
    xfer(1'b1, OFF_BACKUP_DATA0, 32'h5A5A);
    `CHK("locked", 1'b1, errv)
    unlock <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (i = 0; i < 10; i++)
      xfer(1'b1, OFF_BACKUP_DATA0 + 8'(4 * i), 32'hFFFFA500 | 32'(i));
    for (i = 0; i < 10; i++)
      rd(OFF_BACKUP_DATA0 + 8'(4 * i), 32'h0000A500 | 32'(i),
         "bkp");
    xfer(1'b0, 8'h48, 32'h0);
    `CHK("unmapped", 1'b1, errv)
    xfer(1'b1, OFF_BACKUP_DOMAIN_CONTROL, 32'h00000001);
    do xfer(1'b0, OFF_BACKUP_DOMAIN_CONTROL, 32'h0);
    while (rdv[BD_XTAL_RDY] !== 1'b1);
    xfer(1'b1, OFF_BACKUP_DOMAIN_CONTROL, 32'h0000C101);
    do xfer(1'b0, OFF_TIMEKEEPER_CONTROL_LOW, 32'h0);
    while (rdv[CL_SYNC_F] !== 1'b1);
    xfer(1'b1, OFF_RELOAD, 32'h7FFF);
    rd(OFF_RELOAD, 32'h7FFF, "crystal reload");
    xfer(1'b1, OFF_RELOAD, 32'h31);
    rd(OFF_RELOAD, 32'h31, "mains reload");
    xfer(1'b1, OFF_RELOAD, 32'h2);
    rd(OFF_RELOAD, 32'h2, "reload");
    xfer(1'b1, OFF_ALARM, 32'h6);
    xfer(1'b1, OFF_TIMEKEEPER_CONTROL_HIGH, 32'h5);
    xfer(1'b1, OFF_COUNT, 32'h0);
    `CHK("osc on", 1'b1, oscOn)
    `CHK("cal out", 1'b1, tamperOe)
    // Six ticks of three slow edges each; divider phase is unknown
    i = 0;
    while (alrIrq !== 1'b1) begin
      @(posedge ref_clk);
      i++;
    end
    `CHK("tick span", 1'b1, i >= 120 && i <= 160)
    rd(OFF_COUNT, 32'h6, "count");
    `CHK("second irq", 1'b1, secIrq)
    `CHK("wake line", 1'b1, wake)
    `CHK("overflow irq", 1'b0, ovfIrq)
    rd(OFF_BACKUP_DOMAIN_CONTROL, 32'h0000C103, "domain ctl");
    xfer(1'b1, OFF_TIMEKEEPER_CONTROL_LOW, 32'h0);
    `CHK("alarm clear", 1'b0, alrIrq)
    // End of day: alarm at 86399, then counter back to zero
    xfer(1'b1, OFF_ALARM, 32'h0001517F);
    xfer(1'b1, OFF_COUNT, 32'h0001517E);
    while (alrIrq !== 1'b1) @(posedge ref_clk);
    rd(OFF_COUNT, 32'h0001517F, "end of day");
    xfer(1'b1, OFF_COUNT, 32'h0);
    xfer(1'b1, OFF_BACKUP_DATA0 + 8'h04, 32'h0102);
    rd(OFF_BACKUP_DATA0 + 8'h04, 32'h0102, "date");
    xfer(1'b1, OFF_TIMEKEEPER_CONTROL_HIGH, 32'h7);
    xfer(1'b1, OFF_COUNT, 32'hFFFFFFFF);
    while (ovfIrq !== 1'b1) @(posedge ref_clk);
    rd(OFF_COUNT, 32'h0, "wrapped");
    rd(OFF_TIMEKEEPER_CONTROL_LOW, 32'h0000002F, "flags");
    // Calibration pin: half period is 32 slow edges of 8 cycles
    while (tamperPin !== 1'b1) @(posedge ref_clk);
    while (tamperPin !== 1'b0) @(posedge ref_clk);
    i = 0;
    while (tamperPin !== 1'b1) begin
      @(posedge ref_clk);
      i++;
    end
    `CHK("cal half period", 256, i)
    close_out();
  end
endmodule
